// File: design/ref_monitor_irq_enable.sv
// Purpose: reference-missing thresholds, alarm status flags and
//          interrupt enables behind the serial configuration port.
// Assumes: the serial port decoder presents one-cycle read and write
//          strobes with a 16-bit address and 8-bit data, and holds
//          the address steady while a strobe is high.
// Notes:   alarms are level or pulse inputs; any high cycle sets a flag.
//          A level alarm that stays high keeps its flag set through
//          every clear, so the host should remove the cause first.
//          Read data follows the strobe by one edge and then holds.
//
// Notes on behaviour
// - per reference, a 17-bit monitor-period count declares it missing
// - lock-loss enable, reset zero, gates lock-loss flag onto the interrupt
// - holdover enable, reset zero, gates the holdover flag onto the interrupt
// - per-reference enable, reset zero, gates that reference's missing flag
// - each alarm sets its sticky flag, which stays after the alarm ends
// - a flag clears only on reset or on a host write of one to its bit
`timescale 1ns/1ps
`default_nettype none

// register map seen through the strobe port
//   top byte of a threshold  : bit 0 is count bit 16, rest reserved
//   middle byte              : count bits 15..8
//   low byte                 : count bits 7..0
//   reference 0 bytes        : 0x00B9 top, 0x00BA middle, 0x00BB low
//   reference 1 bytes        : 0x00BC top, 0x00BD middle, 0x00BE low
//   interrupt enables 0x00C7 : bit 6 lock loss, bit 4 holdover,
//                              bits 1..0 one per reference
//   interrupt status  0x0200 : same bit layout, write one to clear
//   any other address reads zero and ignores writes
//   reserved bits read zero; the host must still write them as zero
//   thresholds below three are kept as written, never clamped

module ref_monitor_irq_enable
    import ref_monitor_pkg::*;
#(
    parameter logic [THRESH_W-1:0] THRESH_DEFAULT = THRESH_RESET
) (
    input  wire logic                clock,
    input  wire logic                sys_rst,
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic                reg_wr,
    input  wire logic [DATA_W-1:0]   reg_wdata,
    input  wire logic                reg_rd,
    output logic      [DATA_W-1:0]   reg_rdata,
    input  wire logic                lock_loss_alarm,
    input  wire logic                holdover_alarm,
    input  wire logic [NUM_REFS-1:0] ref_missing_alarm,
    output logic      [THRESH_W-1:0] ref0_missing_threshold,
    output logic      [THRESH_W-1:0] ref1_missing_threshold,
    output logic                     irq_out_n
);

    // the whole block state; one copy is built each cycle and the
    // other registered, so no field can be updated from two places
    typedef struct packed {
        // programmed thresholds, one 17-bit count per reference
        logic [NUM_REFS-1:0][THRESH_W-1:0] threshold;
        // interrupt enables
        logic                              lock_loss_irq_enable;
        logic                              holdover_irq_enable;
        logic [NUM_REFS-1:0]               ref_missing_irq_enable;
        // sticky status flags
        logic                              lock_loss_flag;
        logic                              holdover_flag;
        logic [NUM_REFS-1:0]               ref_missing_flag;
        // registered read data and interrupt level
        logic [DATA_W-1:0]                 rdata;
        logic                              irq_active;
    } state_s;

    // current and next copy of the state
    state_s state_reg;
    state_s state_next;

    // next-state logic: one decode feeds both the write and the read
    // paths, so a byte can never be written at one address and read
    // back from another; every field of the struct is settled here
    always_comb begin
        logic [NUM_REFS-1:0] top_sel;
        logic [NUM_REFS-1:0] mid_sel;
        logic [NUM_REFS-1:0] low_sel;
        logic                en_sel;
        logic                stat_sel;
        logic [DATA_W-1:0]   stat_clr;
        logic [DATA_W-1:0]   rd_val;
        top_sel    = '0;
        mid_sel    = '0;
        low_sel    = '0;
        en_sel     = 1'b0;
        stat_sel   = 1'b0;
        stat_clr   = '0;
        rd_val     = READ_ZERO;
        state_next = state_reg;

        // address decode per reference and for the two shared registers
        for (int i = 0; i < NUM_REFS; i++) begin
            top_sel[i] = (reg_addr == THR_TOP_ADDR[i]);
            mid_sel[i] = (reg_addr == THR_MID_ADDR[i]);
            low_sel[i] = (reg_addr == THR_LOW_ADDR[i]);
        end
        en_sel   = (reg_addr == IRQ_EN_ADDR);
        stat_sel = (reg_addr == IRQ_STAT_ADDR);

        // write-one-to-clear mask; zeros leave their flags alone, and
        // nothing but a write to the status address may clear a flag
        if (reg_wr && stat_sel) begin
            stat_clr = reg_wdata;
        end

        // threshold bytes per reference; only bit 0 of the top byte is
        // kept. bytes land one at a time with no shadow copy, so a monitor
        // counting meanwhile may see a half-written value; program the
        // thresholds while the reference is not being judged
        for (int i = 0; i < NUM_REFS; i++) begin
            if (reg_wr && top_sel[i]) begin
                state_next.threshold[i][THRESH_W-1] =
                    reg_wdata[THR_TOP_BIT];
            end
            if (reg_wr && mid_sel[i]) begin
                state_next.threshold[i][THR_MID_LSB +: DATA_W] =
                    reg_wdata;
            end
            if (reg_wr && low_sel[i]) begin
                state_next.threshold[i][THR_LOW_LSB +: DATA_W] =
                    reg_wdata;
            end
        end

        // threshold read-back; reserved bits of the top byte read zero
        for (int i = 0; i < NUM_REFS; i++) begin
            if (top_sel[i]) begin
                rd_val[THR_TOP_BIT] = state_reg.threshold[i][THRESH_W-1];
            end
            if (mid_sel[i]) begin
                rd_val = state_reg.threshold[i][THR_MID_LSB +: DATA_W];
            end
            if (low_sel[i]) begin
                rd_val = state_reg.threshold[i][THR_LOW_LSB +: DATA_W];
            end
        end

        // a threshold below the legal minimum is kept as written: the
        // host owns that limit, and clamping here would hide its mistake

        // enable register; reserved bits are dropped on write and read
        // back as zero, which is one of the values the host may expect
        if (reg_wr && en_sel) begin
            state_next.lock_loss_irq_enable = reg_wdata[LOCK_LOSS_BIT];
            state_next.holdover_irq_enable  = reg_wdata[HOLDOVER_BIT];
            state_next.ref_missing_irq_enable =
                reg_wdata[REF_BIT_BASE +: NUM_REFS];
        end
        if (en_sel) begin
            rd_val[LOCK_LOSS_BIT] = state_reg.lock_loss_irq_enable;
            rd_val[HOLDOVER_BIT]  = state_reg.holdover_irq_enable;
            rd_val[REF_BIT_BASE +: NUM_REFS] =
                state_reg.ref_missing_irq_enable;
        end

        // sticky flags: a write of one clears, an alarm sets, and when
        // both land in one cycle the alarm wins so no event is lost
        state_next.lock_loss_flag =
            (state_reg.lock_loss_flag & ~stat_clr[LOCK_LOSS_BIT])
            | lock_loss_alarm;
        state_next.holdover_flag =
            (state_reg.holdover_flag & ~stat_clr[HOLDOVER_BIT])
            | holdover_alarm;
        state_next.ref_missing_flag =
            (state_reg.ref_missing_flag
             & ~stat_clr[REF_BIT_BASE +: NUM_REFS])
            | ref_missing_alarm;

        // status read-back shows the flags before this cycle's update, so
        // a read that meets a clear still reports what was pending
        if (stat_sel) begin
            rd_val[LOCK_LOSS_BIT] = state_reg.lock_loss_flag;
            rd_val[HOLDOVER_BIT]  = state_reg.holdover_flag;
            rd_val[REF_BIT_BASE +: NUM_REFS] = state_reg.ref_missing_flag;
        end

        // read data captured on the read strobe and held until the next
        // one, so the host may sample it late without it changing
        if (reg_rd) begin
            state_next.rdata = rd_val;
        end

        // gate each flag by its enable; built from the next state so the
        // interrupt pin moves on the same edge as the flag or enable
        // that causes it, never a cycle behind
        state_next.irq_active =
            (state_next.lock_loss_flag & state_next.lock_loss_irq_enable)
            | (state_next.holdover_flag & state_next.holdover_irq_enable)
            | (|(state_next.ref_missing_flag
                 & state_next.ref_missing_irq_enable));
    end

    // state register with synchronous reset; enables and flags clear,
    // so the interrupt pin comes out of reset released
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg <= '0;
            for (int i = 0; i < NUM_REFS; i++) begin
                state_reg.threshold[i] <= THRESH_DEFAULT;
            end
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from flops, so the pins never glitch while the
    // address bus settles
    assign reg_rdata              = state_reg.rdata;
    assign ref0_missing_threshold = state_reg.threshold[0];
    assign ref1_missing_threshold = state_reg.threshold[1];
    assign irq_out_n              = ~state_reg.irq_active;

endmodule : ref_monitor_irq_enable

`default_nettype wire

// File: inc/ref_monitor_pkg.sv
// Purpose: constants shared by the reference-monitor register and
//          interrupt-gating logic.
// Assumes: 16-bit register addresses, 8-bit register data.
// Notes:   the status bit layout matches the enable bit layout.
package ref_monitor_pkg;

    localparam int          NUM_REFS      = 2;
    localparam int          THRESH_W      = 17;
    localparam int          ADDR_W        = 16;
    localparam int          DATA_W        = 8;

    // smallest legal reference-missing threshold, in monitor periods
    localparam logic [16:0] THRESH_MIN    = 17'h00003;
    // default threshold after reset
    localparam logic [16:0] THRESH_RESET  = 17'h00003;

    // threshold register addresses, indexed by reference
    localparam logic [15:0] THR_TOP_ADDR [NUM_REFS] = '{16'h00B9, 16'h00BC};
    localparam logic [15:0] THR_MID_ADDR [NUM_REFS] = '{16'h00BA, 16'h00BD};
    localparam logic [15:0] THR_LOW_ADDR [NUM_REFS] = '{16'h00BB, 16'h00BE};

    localparam logic [15:0] IRQ_EN_ADDR   = 16'h00C7;
    localparam logic [15:0] IRQ_STAT_ADDR = 16'h0200;

    // bit positions in the enable and status registers
    localparam int          LOCK_LOSS_BIT = 6;
    localparam int          HOLDOVER_BIT  = 4;
    localparam int          REF_BIT_BASE  = 0;

    // bit 0 of a top threshold byte holds count bit 16; the middle and
    // low bytes start at these count bits
    localparam int          THR_TOP_BIT   = 0;
    localparam int          THR_MID_LSB   = 8;
    localparam int          THR_LOW_LSB   = 0;

    localparam logic [7:0]  READ_ZERO     = 8'h00;

endpackage : ref_monitor_pkg

// File: verification/ref_monitor_assertions.sv
// Purpose: port checks of the interrupt gating
// Assumes: enables are mirrored from host writes
// Notes:   bound below the module
`timescale 1ns/1ps
`default_nettype none
module ref_monitor_assertions
    import ref_monitor_pkg::*;
(
    input wire logic                clock,
    input wire logic                sys_rst,
    input wire logic [ADDR_W-1:0]   reg_addr,
    input wire logic                reg_wr,
    input wire logic [DATA_W-1:0]   reg_wdata,
    input wire logic                reg_rd,
    input wire logic [DATA_W-1:0]   reg_rdata,
    input wire logic                lock_loss_alarm,
    input wire logic                holdover_alarm,
    input wire logic [NUM_REFS-1:0] ref_missing_alarm,
    input wire logic [THRESH_W-1:0] ref1_missing_threshold,
    input wire logic                irq_out_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic [7:0] en_reg;
    logic       stat_wr;
    assign stat_wr = reg_wr && reg_addr == IRQ_STAT_ADDR;
    // mirror of the enable register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            en_reg <= 8'h00;
        end else if (reg_wr && reg_addr == IRQ_EN_ADDR) begin
            en_reg <= reg_wdata & 8'h53;
        end
    end
    a_lock_raise: assert property (lock_loss_alarm && en_reg[6] |=>
        !irq_out_n) else $error("lock loss irq missing");
    a_hold_raise: assert property (holdover_alarm && en_reg[4] |=>
        !irq_out_n) else $error("holdover irq missing");
    a_ref_raise: assert property (|(ref_missing_alarm & en_reg[1:0])
        |=> !irq_out_n) else $error("reference irq missing");
    a_flag_sticky: assert property (!irq_out_n && !reg_wr |=>
        !irq_out_n) else $error("irq dropped without write");
    a_zero_keep: assert property (stat_wr && reg_wdata == 8'h00
        && !irq_out_n |=> !irq_out_n) else $error("zero write cleared");
    a_none_enabled: assert property (en_reg == 8'h00 && !reg_wr
        |=> irq_out_n) else $error("irq with no enable");
    a_thr_low: assert property (reg_wr && reg_addr == THR_LOW_ADDR[1]
        |=> ref1_missing_threshold[7:0] == $past(reg_wdata))
        else $error("threshold low byte wrong");
    a_en_read: assert property (reg_rd && reg_addr == IRQ_EN_ADDR
        |=> reg_rdata == $past(en_reg)) else $error("enable readback");
    a_set_wins: assert property (stat_wr && reg_wdata[4]
        && holdover_alarm && en_reg[4] |=> !irq_out_n)
        else $error("clear beat a same-cycle alarm");
    c_set_wins: cover property (stat_wr && holdover_alarm);
    c_irq_low: cover property ($fell(irq_out_n));
    c_irq_clear: cover property (stat_wr ##1 $rose(irq_out_n));
    c_thr_write: cover property (reg_wr && reg_addr == THR_TOP_ADDR[1]);
endmodule : ref_monitor_assertions
bind ref_monitor_irq_enable ref_monitor_assertions chk_u (.clock(clock),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .lock_loss_alarm(lock_loss_alarm), .holdover_alarm(holdover_alarm),
    .ref_missing_alarm(ref_missing_alarm),
    .ref1_missing_threshold(ref1_missing_threshold),
    .irq_out_n(irq_out_n));
`default_nettype wire

// File: verification/ref_monitor_host.sv
// Purpose: host model driving the register strobe port
// Assumes: strobes change 1 ns after the rising edge
// Notes:   released data shows the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module ref_monitor_host
    import ref_monitor_pkg::*;
(
    input  wire logic              clock,
    output logic      [ADDR_W-1:0] reg_addr,
    output logic                   reg_wr,
    output logic      [DATA_W-1:0] reg_wdata,
    output logic                   reg_rd,
    input  wire logic [DATA_W-1:0] reg_rdata
);
    // idle port at time zero
    initial begin
        reg_addr = '0;
        reg_wr = 1'b0;
        reg_wdata = '0;
        reg_rd = 1'b0;
    end
    // one-cycle write; thresholds stay >= 3, reserved bits 0
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        #1 reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clock);
        #1 reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask : wr
    // one-cycle read; data is taken once the strobe edge has landed
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clock);
        #1 reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clock);
        #1 reg_rd = 1'b0;
        d = reg_rdata;
    endtask : rd
endmodule : ref_monitor_host
`default_nettype wire

// File: verification/ref_monitor_irq_enable_tb.sv
// Purpose: register and interrupt tests
// Assumes: inputs change 1 ns after the rising edge
// Notes:   one alarm bit per enable bit
`timescale 1ns/1ps
`default_nettype none
module ref_monitor_irq_enable_tb
    import ref_monitor_pkg::*;
;
    logic clock = 1'b0, sys_rst = 1'b1, reg_wr, reg_rd, irq_out_n;
    logic [15:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd_val, al = 8'h00;
    logic [16:0] thr0, thr1;
    logic [7:0] bits [4] = '{8'h40, 8'h10, 8'h02, 8'h01};
    int n_errors = 0, checked = 0;
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin \
    n_errors++; $display("Error %s expected %h seen %h", nm, e, a); end end
    always #5 clock = ~clock;
    ref_monitor_host host_u (.clock(clock), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    ref_monitor_irq_enable dut_u (.clock(clock), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lock_loss_alarm(al[6]),
        .holdover_alarm(al[4]), .ref_missing_alarm(al[1:0]),
        .ref0_missing_threshold(thr0), .ref1_missing_threshold(thr1),
        .irq_out_n(irq_out_n));
    // one-cycle alarm pulse, then a few idle cycles
    task automatic pulse(input logic [7:0] m);
        @(posedge clock);
        #1 al = m;
        @(posedge clock);
        #1 al = 8'h00;
        repeat (3) @(posedge clock);
    endtask : pulse
    // verdict and end of run
    task automatic end_sim();
        if (n_errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    // watchdog
    initial begin
        #20000;
        n_errors++;
        end_sim();
    end
    // main sequence
    initial begin
        repeat (3) @(posedge clock);
        #1 sys_rst = 1'b0;
        host_u.rd(IRQ_EN_ADDR, rd_val);
        `CHK("enables", 8'h00, rd_val)
        `CHK("thr0", THRESH_RESET, thr0)
        host_u.wr(THR_TOP_ADDR[1], 8'h01);
        host_u.wr(THR_MID_ADDR[1], 8'h23);
        host_u.wr(THR_LOW_ADDR[1], 8'h45);
        `CHK("thr1", 17'h12345, thr1)
        host_u.wr(THR_TOP_ADDR[0], 8'h01);
        host_u.wr(THR_MID_ADDR[0], 8'hA5);
        host_u.wr(THR_LOW_ADDR[0], 8'h3C);
        `CHK("thr0 set", 17'h1A53C, thr0)
        `CHK("thr1 kept", 17'h12345, thr1)
        host_u.rd(THR_TOP_ADDR[0], rd_val);
        `CHK("thr0 top", 8'h01, rd_val)
        host_u.rd(THR_MID_ADDR[0], rd_val);
        `CHK("thr0 mid", 8'hA5, rd_val)
        host_u.rd(THR_LOW_ADDR[1], rd_val);
        `CHK("thr1 low", 8'h45, rd_val)
        host_u.rd(16'h00BF, rd_val);
        `CHK("unmapped", 8'h00, rd_val)
        pulse(8'h40);
        `CHK("masked irq", 1'b1, irq_out_n)
        host_u.wr(IRQ_EN_ADDR, 8'h40);
        `CHK("enabled irq", 1'b0, irq_out_n)
        host_u.rd(IRQ_STAT_ADDR, rd_val);
        `CHK("status", 8'h40, rd_val)
        host_u.wr(IRQ_STAT_ADDR, 8'h00);
        `CHK("zero write", 1'b0, irq_out_n)
        for (int i = 0; i < 4; i++) begin
            host_u.wr(IRQ_EN_ADDR, bits[i]);
            host_u.rd(IRQ_EN_ADDR, rd_val);
            `CHK("enable", bits[i], rd_val)
            host_u.wr(IRQ_STAT_ADDR, 8'h53);
            `CHK("cleared", 1'b1, irq_out_n)
            pulse(8'h53 & ~bits[i]);
            `CHK("others", 1'b1, irq_out_n)
            pulse(bits[i]);
            `CHK("raised", 1'b0, irq_out_n)
            host_u.rd(IRQ_STAT_ADDR, rd_val);
            `CHK("all flags", 8'h53, rd_val)
        end
        // a clear that meets an alarm on the same edge leaves it set
        host_u.wr(IRQ_EN_ADDR, 8'h10);
        fork
            host_u.wr(IRQ_STAT_ADDR, 8'h53);
            pulse(8'h10);
        join
        host_u.rd(IRQ_STAT_ADDR, rd_val);
        `CHK("set wins", 8'h10, rd_val)
        `CHK("set wins irq", 1'b0, irq_out_n)
        host_u.wr(IRQ_STAT_ADDR, 8'h10);
        `CHK("released", 1'b1, irq_out_n)
        end_sim();
    end
endmodule : ref_monitor_irq_enable_tb
`default_nettype wire
